// ### qom_counter_model.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------
// Far-side incremental counter: decodes A/B, measures edge gaps
// -----------------------------------------------------------------
module qom_counter_model (
    input  wire logic mclk_i,
    input  wire logic clear_i,
    input  wire logic oe_n_i,
    input  wire logic err_n_i,
    input  wire logic a_i,
    input  wire logic b_i,
    input  wire logic z_i,
    output int        count_o,
    output int        min_gap_o,
    output int        bad_o,
    output logic      trusted_o
);
    logic [2:0] abz_q = 3'h0;
    int         gap_q = 0;

    // Gray state to position modulo four
    function automatic logic [1:0] pos(input logic [1:0] ab);
        return {ab[1], ab[1] ^ ab[0]};
    endfunction

    initial begin
        count_o   = 0;
        min_gap_o = 1000;
        bad_o     = 0;
        trusted_o = 1'b1;
    end

    // Floating pins are ignored, a pull-up would fake edges there
    always @(posedge mclk_i) begin
        gap_q <= gap_q + 1;
        if (clear_i) begin
            min_gap_o <= 1000;
            bad_o     <= 0;
            trusted_o <= 1'b1;
        end
        if (!err_n_i) begin
            trusted_o <= 1'b0;
        end
        if (!oe_n_i && {a_i, b_i, z_i} !== abz_q) begin
            abz_q <= {a_i, b_i, z_i};
            gap_q <= 1;
            if (!clear_i && gap_q < min_gap_o) begin
                min_gap_o <= gap_q;
            end
            case (pos({a_i, b_i}) - pos(abz_q[2:1]))
                2'h0: ;
                2'h1: count_o <= count_o + 1;
                2'h3: count_o <= count_o - 1;
                default: bad_o <= bad_o + 1;
            endcase
        end
    end
endmodule

// ### qom_defines.svh
`ifndef QOM_DEFINES_SVH
`define QOM_DEFINES_SVH

// -----------------------------------------------------------------
// Register map (byte addresses)
// -----------------------------------------------------------------
`define QOM_ADDR_CFG    12'h000
`define QOM_ADDR_MON    12'h004
`define QOM_ADDR_RATE   12'h008
`define QOM_ADDR_STAT   12'h00c

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define QOM_F_TPP       2:0
`define QOM_F_DIV       5:4
`define QOM_F_HYST      10:8
`define QOM_F_ZANG      20:16
`define QOM_B_Z4        21
`define QOM_B_HOLD      22
`define QOM_B_TRI       23
`define QOM_F_EN        8:0
`define QOM_F_LATCH     24:16
`define QOM_F_RATE      12:0
`define QOM_F_ABZ       18:16

// -----------------------------------------------------------------
// Reset values, source indices and limits
// -----------------------------------------------------------------
`define QOM_ZANG_RST    5'h04
`define QOM_RATE_RST    13'h0400
`define QOM_E_VEC       0
`define QOM_E_SADC      1
`define QOM_E_CADC      2
`define QOM_E_SOFF      3
`define QOM_E_COFF      4
`define QOM_E_GAIN      5
`define QOM_E_FAST      6
`define QOM_E_ABZ       7
`define QOM_E_NON       8
`define QOM_WARN_MASK   9'h038
`define QOM_ERR_MASK    9'h147
`define QOM_NON_DIV     24'h0000c6
`define QOM_CNT_DIV     24'h000118
`define QOM_RATE_NUM    24'h00000a
`define QOM_RATE_DEN    24'h000009
`define QOM_PER_MAX     24'hffffff
`define QOM_TMR_ONE     8'h01
`endif

// ### qom_edge_timer.sv
`timescale 1ns/10ps
`include "qom_defines.svh"
module qom_edge_timer (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       load_i,
    input  wire logic [2:0] exp_i,
    output logic            ready_o
);
    import qom_pkg::*;

    qom_tmr_t st;
    qom_tmr_t nx;

    // -----------------------------------------------------------------
    // Spacing counter
    // -----------------------------------------------------------------
    // Reload with N-1 so the next edge comes N cycles later
    always_comb begin
        nx = st;
        if (load_i) begin
            nx.cnt = 7'((`QOM_TMR_ONE << exp_i) - `QOM_TMR_ONE);
        end else if (st.cnt != 7'h00) begin
            nx.cnt = st.cnt - 7'h01;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign ready_o = (st.cnt == 7'h00);

    a_load_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
        load_i |-> ready_o)
        else $error("edge spacing timer loaded before expiry");
endmodule

// ### qom_pkg.sv
package qom_pkg;
    // Quadrature states, Gray order along forward motion
    typedef enum logic [1:0] {
        QOM_Q00 = 2'h0,
        QOM_Q01 = 2'h1,
        QOM_Q11 = 2'h3,
        QOM_Q10 = 2'h2
    } qom_quad_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } qom_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } qom_apb_rsp_t;

    typedef struct packed {
        logic [2:0]  edge_spacing_exponent;
        logic [1:0]  div;
        logic [2:0]  hyst;
        logic [4:0]  zang;
        logic        z4;
        logic        hold;
        logic        tri_en;
        logic [8:0]  en;
        logic [8:0]  latch;
        logic [12:0] interp_rate;
    } qom_cfg_t;

    typedef struct packed {
        logic [6:0] cnt;
    } qom_tmr_t;

    typedef struct packed {
        qom_cfg_t     cfg;
        logic [8:0]   flags;
        logic [2:0]   ref_s;
        logic         ref_ok;
        logic [2:0]   pre_s;
        logic         pre_ok;
        logic         chg;
        logic [18:0]  base;
        logic [15:0]  outp;
        qom_quad_t    quad;
        logic         z;
        logic         oe_n;
        logic         err_n;
        logic         warn;
        logic         serr;
        logic [23:0]  per;
        logic [23:0]  last;
        qom_apb_rsp_t rsp;
    } qom_core_t;
endpackage

// ### qom_top.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "qom_defines.svh"
module qom_top (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire qom_pkg::qom_apb_req_t apb_req_i,
    output qom_pkg::qom_apb_rsp_t      apb_rsp_o,
    input  wire logic                  step_i,
    input  wire logic                  dir_i,
    input  wire logic                  period_tick_i,
    input  wire logic [4:0]            phase_i,
    input  wire logic                  reference_above_i,
    input  wire logic                  preset_i,
    input  wire logic                  counter_reset_cmd_i,
    input  wire logic [8:0]            raw_fault_i,
    output logic                       a_o,
    output logic                       b_o,
    output logic                       z_o,
    output logic                       abz_oe_n_o,
    output logic                       error_out_n_o,
    output logic                       warn_o,
    output logic                       serr_o
);
    import qom_pkg::*;

    qom_core_t    st;
    qom_core_t    n;
    logic         tmr_ready;
    logic         edge_w;
    logic         ab_step;
    logic         acc;
    logic         wr;
    logic         clr;
    logic         pre_rise;
    logic         up;
    logic         dn;
    logic         z_want;
    logic         can;
    logic [15:0]  tgt;
    logic signed [15:0] diff;
    logic [23:0]  lim;
    logic [8:0]   raw;
    logic [31:0]  rd;

    // Step forward or back one Gray state
    function automatic qom_quad_t quad_step(input qom_quad_t q, input logic fwd);
        qom_quad_t r;
        r = q;
        case (q)
            QOM_Q00: r = fwd ? QOM_Q01 : QOM_Q10;
            QOM_Q01: r = fwd ? QOM_Q11 : QOM_Q00;
            QOM_Q11: r = fwd ? QOM_Q10 : QOM_Q01;
            QOM_Q10: r = fwd ? QOM_Q00 : QOM_Q11;
            default: r = QOM_Q00;
        endcase
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Edge spacing timer
    // -----------------------------------------------------------------
    qom_edge_timer u_timer (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .load_i  (edge_w),
        .exp_i   (st.cfg.edge_spacing_exponent),
        .ready_o (tmr_ready)
    );

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        n = st;
        rd = '0;
        edge_w = 1'b0;
        ab_step = 1'b0;

        // Pin synchronisers: value moves once stages two and three agree
        n.ref_s = {st.ref_s[1:0], reference_above_i};
        n.pre_s = {st.pre_s[1:0], preset_i};
        if (st.ref_s[1] == st.ref_s[2]) begin
            n.ref_ok = st.ref_s[2];
        end
        if (st.pre_s[1] == st.pre_s[2]) begin
            n.pre_ok = st.pre_s[2];
        end
        pre_rise = (st.pre_s[1] == st.pre_s[2]) && st.pre_s[2] && !st.pre_ok;

        // APB: one wait state so read data can come from a register
        acc = apb_req_i.psel && apb_req_i.penable;
        wr = acc && st.rsp.pready && apb_req_i.pwrite;
        n.rsp.pready = acc && !st.rsp.pready;
        n.rsp.pslverr = 1'b0;
        n.rsp.prdata = '0;
        n.chg = 1'b0;
        if (acc && !st.rsp.pready) begin
            case (apb_req_i.paddr)
                `QOM_ADDR_CFG: begin
                    rd[`QOM_F_TPP] = st.cfg.edge_spacing_exponent;
                    rd[`QOM_F_DIV] = st.cfg.div;
                    rd[`QOM_F_HYST] = st.cfg.hyst;
                    rd[`QOM_F_ZANG] = st.cfg.zang;
                    rd[`QOM_B_Z4] = st.cfg.z4;
                    rd[`QOM_B_HOLD] = st.cfg.hold;
                    rd[`QOM_B_TRI] = st.cfg.tri_en;
                end
                `QOM_ADDR_MON: begin
                    rd[`QOM_F_EN] = st.cfg.en;
                    rd[`QOM_F_LATCH] = st.cfg.latch;
                end
                `QOM_ADDR_RATE: rd[`QOM_F_RATE] = st.cfg.interp_rate;
                `QOM_ADDR_STAT: begin
                    rd[`QOM_F_EN] = st.flags;
                    rd[`QOM_F_ABZ] = {st.quad, st.z};
                end
                default: n.rsp.pslverr = 1'b1;
            endcase
            n.rsp.prdata = rd;
        end
        if (wr) begin
            case (apb_req_i.paddr)
                `QOM_ADDR_CFG: begin
                    n.cfg.edge_spacing_exponent = apb_req_i.pwdata[`QOM_F_TPP];
                    n.cfg.div = apb_req_i.pwdata[`QOM_F_DIV];
                    n.cfg.hyst = apb_req_i.pwdata[`QOM_F_HYST];
                    n.cfg.zang = apb_req_i.pwdata[`QOM_F_ZANG];
                    n.cfg.z4 = apb_req_i.pwdata[`QOM_B_Z4];
                    n.cfg.hold = apb_req_i.pwdata[`QOM_B_HOLD];
                    n.cfg.tri_en = apb_req_i.pwdata[`QOM_B_TRI];
                    n.chg = (n.cfg.edge_spacing_exponent != st.cfg.edge_spacing_exponent) || (n.cfg.div != st.cfg.div);
                end
                `QOM_ADDR_MON: begin
                    n.cfg.en = apb_req_i.pwdata[`QOM_F_EN];
                    n.cfg.latch = apb_req_i.pwdata[`QOM_F_LATCH];
                end
                `QOM_ADDR_RATE: begin
                    n.cfg.interp_rate = apb_req_i.pwdata[`QOM_F_RATE];
                    n.chg = (n.cfg.interp_rate != st.cfg.interp_rate);
                end
                default: n.chg = 1'b0;
            endcase
        end

        // Base position; the divided view is just a right shift
        if (step_i) begin
            n.base = dir_i ? st.base + 19'h00001 : st.base - 19'h00001;
        end
        tgt = 16'(st.base >> st.cfg.div);

        // Input period in oscillator cycles, saturating when stopped
        n.per = period_tick_i ? 24'h000000 :
                (st.per == `QOM_PER_MAX) ? st.per : st.per + 24'h000001;
        if (period_tick_i || (st.per > st.last)) begin
            n.last = st.per;
        end
        // A stopped input stretches the last period to the running count and clears the fault
        lim = 24'((((24'(st.cfg.interp_rate) >> st.cfg.div) << st.cfg.edge_spacing_exponent) * `QOM_RATE_NUM)
                  / `QOM_RATE_DEN);

        // Fault sources; frequency checks are folded in here
        raw = raw_fault_i;
        raw[`QOM_E_NON] = raw_fault_i[`QOM_E_NON] || (st.last < `QOM_NON_DIV);
        raw[`QOM_E_FAST] = raw_fault_i[`QOM_E_FAST] || (st.last < `QOM_CNT_DIV);
        raw[`QOM_E_ABZ] = raw_fault_i[`QOM_E_ABZ] || (st.last < lim) || st.chg;

        // Masked flags; latched bits survive, a new set beats a clear
        clr = counter_reset_cmd_i || pre_rise;
        n.flags = ((clr ? 9'h000 : st.flags) & st.cfg.latch) | (raw & st.cfg.en);
        n.err_n = ~|n.flags;
        n.warn = |(n.flags & `QOM_WARN_MASK);
        n.serr = |(n.flags & `QOM_ERR_MASK);
        n.oe_n = st.cfg.tri_en && (|st.flags);

        // Output motion; hysteresis keeps the output one step behind
        diff = $signed(tgt - st.outp);
        if (st.cfg.hyst != 3'h0) begin
            up = diff > 16'sd1;
            dn = diff < -16'sd1;
        end else begin
            up = diff > 16'sd0;
            dn = diff < 16'sd0;
        end
        z_want = st.ref_ok && (phase_i == st.cfg.zang) &&
                 (st.cfg.z4 || (st.quad == QOM_Q11));
        can = tmr_ready && !(st.cfg.hold && (|st.flags));

        // One edge per spacing slot; a short index falls before A/B move
        if (can) begin
            if (st.z && (!z_want || ((up || dn) && !st.cfg.z4))) begin
                n.z = 1'b0;
                edge_w = 1'b1;
            end else if (up || dn) begin
                n.quad = quad_step(st.quad, up);
                n.outp = up ? st.outp + 16'h0001 : st.outp - 16'h0001;
                edge_w = 1'b1;
                ab_step = 1'b1;
            end else if (z_want && !st.z) begin
                n.z = 1'b1;
                edge_w = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.cfg.zang <= `QOM_ZANG_RST;
            st.cfg.interp_rate <= `QOM_RATE_RST;
            st.err_n <= 1'b1;
            st.per <= `QOM_PER_MAX;
            st.last <= `QOM_PER_MAX;
        end else begin
            st <= n;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp_o = st.rsp;
    assign a_o = st.quad[1];
    assign b_o = st.quad[0];
    assign z_o = st.z;
    assign abz_oe_n_o = st.oe_n;
    assign error_out_n_o = st.err_n;
    assign warn_o = st.warn;
    assign serr_o = st.serr;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    logic [7:0] since_q;
    logic [7:0] span_q;

    // Cycles since the last edge, and the spacing loaded at that edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            since_q <= 8'hff;
            span_q <= 8'h01;
        end else if (edge_w) begin
            since_q <= 8'h00;
            span_q <= `QOM_TMR_ONE << st.cfg.edge_spacing_exponent;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_err_hold;
        st.cfg.hold && (|st.flags);
    endsequence

    sequence s_latched_clear;
        clr ##1 1'b1;
    endsequence

    a_edge_spacing: assert property (
        edge_w |-> (since_q >= (span_q - 8'h01)))
        else $error("output edge came before the minimum spacing");

    a_gray_order: assert property (
        $changed(st.quad) |-> ($countones(st.quad ^ $past(st.quad)) == 1))
        else $error("A and B changed together");

    a_index_cause: assert property (
        $rose(st.z) |-> $past(st.ref_ok && (phase_i == st.cfg.zang)))
        else $error("index rose without phase match and reference");

    a_index_ab_high: assert property (
        ($rose(st.z) && !st.cfg.z4) |-> (st.quad == QOM_Q11))
        else $error("short index outside A and B high");

    a_hold_freeze: assert property (
        s_err_hold |=> ($stable(st.quad) && $stable(st.z)))
        else $error("outputs moved while held on error");

    a_tristate_err: assert property (
        (st.cfg.tri_en && (|st.flags)) |=> st.oe_n)
        else $error("outputs driven during error with tristate set");

    a_error_pin: assert property (
        $past(|n.flags) |-> !error_out_n_o)
        else $error("error pin not low with a flag set");

    a_hyst_quiet: assert property (
        ((st.cfg.hyst != 3'h0) && (diff >= -16'sd1) && (diff <= 16'sd1)) |-> !ab_step)
        else $error("hysteresis let a one-increment wobble through");

    a_clear_flags: assert property (
        s_latched_clear |-> ((st.flags & ~$past(raw & st.cfg.en)) == 9'h000))
        else $error("latched flag survived a clear");

    a_rate_not_serial: assert property (
        (n.flags == (9'h001 << `QOM_E_ABZ)) |=> (!serr_o && !warn_o))
        else $error("output rate fault reported on serial bits");
endmodule

// ### quadrature_output_and_monitor_tb.sv
`timescale 1ns/10ps
`include "qom_defines.svh"
module quadrature_output_and_monitor_tb;
    import qom_pkg::*;
    logic         mclk_i, rst_i, step_i, dir_i, period_tick_i, preset_i;
    logic         reference_above_i, counter_reset_cmd_i, clr;
    logic [4:0]   phase_i;
    logic [8:0]   raw_fault_i;
    qom_apb_req_t req;
    qom_apb_rsp_t rsp;
    logic         a_o, b_o, z_o, abz_oe_n_o, error_out_n_o, warn_o, serr_o, ptr, er;
    logic [31:0]  rd;
    int           errors, tests_run, cnt, hits, pc, pg, pb;
    int           per[4] = '{1200, 1000, 250, 190};
    logic [31:0]  fx[4]  = '{32'h0, 32'h80, 32'hc0, 32'h1c0};
    tri1          a_pin, b_pin, z_pin;

    // Pins float high through pull-ups when the outputs are disabled
    assign a_pin = abz_oe_n_o ? 1'bz : a_o;
    assign b_pin = abz_oe_n_o ? 1'bz : b_o;
    assign z_pin = abz_oe_n_o ? 1'bz : z_o;

    qom_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .step_i(step_i), .dir_i(dir_i), .period_tick_i(period_tick_i), .phase_i(phase_i),
        .reference_above_i(reference_above_i), .preset_i(preset_i),
        .counter_reset_cmd_i(counter_reset_cmd_i), .raw_fault_i(raw_fault_i), .a_o(a_o),
        .b_o(b_o), .z_o(z_o), .abz_oe_n_o(abz_oe_n_o), .error_out_n_o(error_out_n_o),
        .warn_o(warn_o), .serr_o(serr_o));
    qom_counter_model u_cnt (.mclk_i(mclk_i), .clear_i(clr), .oe_n_i(abz_oe_n_o),
        .err_n_i(error_out_n_o), .a_i(a_pin), .b_i(b_pin), .z_i(z_pin), .count_o(pc),
        .min_gap_o(pg), .bad_o(pb), .trusted_o(ptr));

    // -----------------------------------------------------------------
    // Clock, tasks
    // -----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        @(posedge mclk_i);
        req <= '{1'b1, 1'b0, w, ad, wd};
        @(posedge mclk_i);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 64);
        rd = rsp.prdata;
        er = rsp.pslverr;
        if (n >= 64) begin
            errors++;
            conclude();
        end
        req <= '0;
    endtask

    task automatic rdc(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(rd & m, e);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic stp(input logic d, input int k);
        repeat (k) begin
            @(posedge mclk_i);
            step_i <= 1'b1;
            dir_i  <= d;
            @(posedge mclk_i);
            step_i <= 1'b0;
        end
    endtask

    task automatic tick(input int p);
        repeat (3) begin
            repeat (p - 1) @(posedge mclk_i);
            period_tick_i <= 1'b1;
            @(posedge mclk_i);
            period_tick_i <= 1'b0;
        end
    endtask

    task automatic drv(input logic [8:0] v);
        @(posedge mclk_i);
        raw_fault_i <= v;
    endtask

    task automatic pls(input int which);
        @(posedge mclk_i);
        if (which == 0) clr <= 1'b1; else counter_reset_cmd_i <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
        counter_reset_cmd_i <= 1'b0;
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 80000 cycles
    initial begin
        repeat (80000) @(posedge mclk_i);
        errors++;
        conclude();
    end

    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial begin
        {rst_i, step_i, dir_i, period_tick_i, preset_i, clr} = 6'h20;
        {reference_above_i, counter_reset_cmd_i, phase_i, raw_fault_i} = '0;
        req = '0;
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        wt(1);
        chk(error_out_n_o, 1'b1);
        rdc(`QOM_ADDR_CFG, 32'hffffffff, 32'h00040000);
        rdc(`QOM_ADDR_RATE, 32'hffffffff, 32'h400);
        rdc(`QOM_ADDR_MON, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, `QOM_ADDR_STAT, 32'hffffffff);
        chk(er, 1'b0);
        rdc(`QOM_ADDR_STAT, 32'h1ff, 32'h0);
        $display("test registers done");
        pls(0);
        stp(1'b1, 8);
        wt(4);
        chk(pc, 8);
        stp(1'b0, 5);
        wt(4);
        chk(pc, 3);
        chk(pb, 0);
        $display("test gray order done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `QOM_ADDR_CFG, 32'h40000 | c);
            wt(140);
            pls(0);
            cnt = pc;
            stp(1'b1, 3);
            wt(3 * (1 << c) + 10);
            chk(pc - cnt, 3);
            chk(pg, (c == 0) ? 2 : (1 << c));
        end
        $display("test edge spacing done");
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, `QOM_ADDR_CFG, 32'h40000 | (v << 4));
            // A new divider rescales the target; let the output catch up first
            wt(40);
            cnt = pc;
            stp(1'b1, 8);
            wt(20);
            chk(pc - cnt, 8 >> v);
        end
        $display("test divider done");
        apb(1'b1, `QOM_ADDR_CFG, 32'h40100);
        stp(1'b1, 3);
        // Divider back to one: dozens of catch-up edges before it settles
        wt(80);
        cnt = pc;
        stp(1'b0, 1);
        wt(10);
        chk(pc - cnt, 0);
        stp(1'b1, 1);
        wt(10);
        chk(pc - cnt, 0);
        stp(1'b1, 1);
        wt(10);
        chk(pc - cnt, 1);
        $display("test hysteresis done");
        apb(1'b1, `QOM_ADDR_CFG, 32'h240000);
        @(posedge mclk_i);
        {reference_above_i, phase_i} <= 6'h24;
        wt(10);
        chk(z_o, 1'b1);
        @(posedge mclk_i);
        reference_above_i <= 1'b0;
        wt(10);
        chk(z_o, 1'b0);
        @(posedge mclk_i);
        {reference_above_i, phase_i} <= 6'h25;
        wt(10);
        chk(z_o, 1'b0);
        for (int w = 0; w < 2; w++) begin
            apb(1'b1, `QOM_ADDR_CFG, 32'h40000 | (w << 21));
            phase_i <= 5'h04;
            hits = 0;
            repeat (4) begin
                stp(1'b1, 1);
                wt(6);
                hits += z_o;
                if (w == 0) chk(z_o, a_o & b_o);
            end
            chk(hits, (w == 1) ? 4 : 1);
        end
        $display("test index done");
        apb(1'b1, `QOM_ADDR_CFG, 32'h40000);
        apb(1'b1, `QOM_ADDR_MON, 32'h1c0);
        for (int i = 0; i < 4; i++) begin
            tick(per[i]);
            rdc(`QOM_ADDR_STAT, 32'h1ff, fx[i]);
        end
        $display("test frequency done");
        apb(1'b1, `QOM_ADDR_MON, 32'h10089);
        // Short periods from the last test linger until the running count passes them
        wt(1200);
        drv(9'h008);
        wt(4);
        chk({warn_o, serr_o, error_out_n_o}, 3'h4);
        drv(9'h080);
        wt(4);
        chk({warn_o, serr_o, error_out_n_o}, 3'h0);
        drv(9'h002);
        wt(4);
        chk(error_out_n_o, 1'b1);
        drv(9'h001);
        drv(9'h000);
        wt(4);
        chk({serr_o, error_out_n_o}, 2'h2);
        rdc(`QOM_ADDR_STAT, 32'h1ff, 32'h1);
        pls(1);
        wt(4);
        chk(error_out_n_o, 1'b1);
        drv(9'h001);
        drv(9'h000);
        preset_i <= 1'b1;
        wt(10);
        @(posedge mclk_i);
        preset_i <= 1'b0;
        wt(4);
        chk(error_out_n_o, 1'b1);
        $display("test error pin done");
        apb(1'b1, `QOM_ADDR_CFG, 32'h840000);
        drv(9'h008);
        wt(5);
        chk({abz_oe_n_o, a_pin}, 2'h3);
        drv(9'h000);
        wt(5);
        chk(abz_oe_n_o, 1'b0);
        apb(1'b1, `QOM_ADDR_CFG, 32'h440000);
        drv(9'h008);
        wt(4);
        cnt = pc;
        stp(1'b1, 2);
        wt(10);
        chk(pc - cnt, 0);
        drv(9'h000);
        wt(10);
        chk(pc - cnt, 2);
        $display("test hold and tristate done");
        conclude();
    end
endmodule
